// >>> dv/acc_conv_ctrl_tb_top.sv
// Purpose: self-checking bench for the conversion control pins
// Assumes: inputs change on falling mclk edges
// Notes:   conversion lengths come from the package cycle counts
module acc_conv_ctrl_tb_top
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, resetIn = 0, power_down_in = 0;
    logic range_scale_select = 0, bipolarSelect = 0;
    logic output_coding_select = 0, serial_parallel_select = 0;
    logic clock_source_select = 0, read_during_convert = 0;
    logic swConfigN = 1, cfgWrite = 0, extSerialClk = 0;
    logic [3:0] cfgData = 4'h0;
    logic [DATA_W-1:0] convResult = 16'ha5c3, dataOut, d;
    logic startN, csN, rdN, busy, holdSample, outputEnable, serialClkGated, en;
    logic [1:0] inputRange;
    int err_total = 0, checks_done = 0, lat, len, i;
    always #4 mclk = ~mclk;
    acc_conv_ctrl dut (.mclk, .rst, .conversion_start_n(startN), .resetIn,
        .power_down_in, .chipSelN(csN), .readN(rdN), .range_scale_select,
        .bipolarSelect, .output_coding_select, .serial_parallel_select,
        .clock_source_select, .read_during_convert, .swConfigN, .cfgWrite,
        .cfgData, .extSerialClk, .convResult, .busy, .holdSample,
        .inputRange, .outputEnable, .dataOut, .serialClkGated);
    acc_host_model host (.mclk, .busy, .outputEnable, .dataOut,
        .startN, .csN, .rdN);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic t_range();
        for (i = 0; i < 4; i++) begin
            @(negedge mclk);
            {bipolarSelect, range_scale_select} = i[1:0];
            repeat (3) @(negedge mclk);
            chk(inputRange, i);
        end
        {bipolarSelect, range_scale_select} = 2'b00;
        $display("range test done");
    endtask
    task automatic t_conv();
        host.convert(lat, len);
        // two sync flops, then the state register
        chk(lat, 3);
        chk(len, CONV_CYCLES);
        host.read(en, d);
        chk(en, 1);
        chk(d, 16'ha5c3);
        chk(outputEnable, 0);
        serial_parallel_select = 1;
        host.convert(lat, len);
        chk(len, CONV_CYCLES + CONV_EXTRA_CYCLES);
        read_during_convert = 1;
        host.convert(lat, len);
        chk(len, CONV_CYCLES);
        read_during_convert = 0;
        serial_parallel_select = 0;
        $display("conversion test done");
    endtask
    task automatic t_pd();
        convResult = 16'h3c5a;
        fork
            host.convert(lat, len);
            begin
                repeat (20) @(negedge mclk);
                power_down_in = 1;
            end
        join
        chk(len, CONV_CYCLES);
        host.convert(lat, len);
        chk(len, 0);
        host.read(en, d);
        chk(en, 1);
        chk(d, 16'h3c5a);
        power_down_in = 0;
        $display("power-down test done");
    endtask
    task automatic t_reset();
        output_coding_select = 1;
        fork
            host.convert(lat, len);
            begin
                repeat (30) @(negedge mclk);
                chk(holdSample, 1);
                resetIn = 1;
            end
        join
        chk(len < CONV_CYCLES, 1);
        resetIn = 0;
        repeat (4) @(negedge mclk);
        host.read(en, d);
        chk(d, 0);
        $display("reset test done");
    endtask
    task automatic t_soft();
        serial_parallel_select = 1;
        swConfigN = 0;
        repeat (3) @(negedge mclk);
        cfgData = 4'h3;
        cfgWrite = 1;
        @(negedge mclk);
        cfgWrite = 0;
        @(negedge mclk);
        chk(inputRange, 2'b11);
        resetIn = 1;
        repeat (4) @(negedge mclk);
        resetIn = 0;
        repeat (4) @(negedge mclk);
        chk(inputRange, 2'b00);
        cfgData = 4'h4;
        cfgWrite = 1;
        @(negedge mclk);
        cfgWrite = 0;
        host.convert(lat, len);
        chk(len, 0);
        swConfigN = 1;
        clock_source_select = 1;
        repeat (4) @(negedge mclk);
        host.hold_cs(1'b0);
        for (i = 0; i < 8; i++) begin
            if (i == 4) host.hold_cs(1'b1);
            extSerialClk = ~extSerialClk;
            repeat (3) @(negedge mclk);
            // clock passes two flops late, and only while cs is low
            chk(serialClkGated, (i < 4) ? extSerialClk : 1'b0);
        end
        $display("software config test done");
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        rst = 0;
        repeat (4) @(negedge mclk);
        t_range();
        t_conv();
        t_pd();
        t_reset();
        t_soft();
        final_report();
    end
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule

// >>> dv/acc_host_model.sv
// Purpose: host side model that starts conversions and reads results
// Assumes: pins change on falling mclk edges only
// Notes:   waits are bounded; a zero length means the start was refused
module acc_host_model
    import acc_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // device status
    input  wire logic              busy,
    input  wire logic              outputEnable,
    input  wire logic [DATA_W-1:0] dataOut,
    // host strobes
    output logic                   startN,
    output logic                   csN,
    output logic                   rdN
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        startN = 1'b1;
        csN    = 1'b1;
        rdN    = 1'b1;
    end
    task automatic convert(output int lat, output int len);
        lat = 0;
        len = 0;
        @(negedge mclk);
        startN = 1'b0;
        while (busy !== 1'b1 && lat < 12) begin
            @(negedge mclk);
            lat++;
            if (lat == 3) startN = 1'b1;
        end
        // no new start until busy has fallen
        while (busy === 1'b1 && len < 400) begin
            @(negedge mclk);
            len++;
        end
        repeat (4) @(negedge mclk);
    endtask
    // chip select gates the slave serial clock while serial and clock source selects are high
    task automatic hold_cs(input logic level);
        @(negedge mclk);
        csN = level;
    endtask
    task automatic read(output logic en, output logic [DATA_W-1:0] d);
        @(negedge mclk);
        csN = 1'b0;
        rdN = 1'b0;
        repeat (3) @(negedge mclk);
        en  = outputEnable;
        d   = dataOut;
        csN = 1'b1;
        rdN = 1'b1;
        repeat (3) @(negedge mclk);
    endtask
endmodule

// >>> rtl/acc_conv_ctrl.sv
// Purpose: conversion control and status logic of the converter
// Assumes: pins are asynchronous to mclk; conversion result supplied
// Notes:   conversion time is a cycle count, not analog timing
// Function
// - busy rises when conversion begins
// - busy holds until result latched
// - master read-after-convert lengthens busy
// - decode scale and bipolar into range
// - output bus enabled only cs, rd low
// - slave serial: chip select gates clock
// - reset high aborts conversion
// - reset fall clears config, and clears data only when output coding select is high
// - power-down finishes current, blocks next
// - interface stays active during power-down
// - start falling edge holds, begins conversion
// - software mode uses config register settings
module acc_conv_ctrl
    import acc_pkg::*;
(
    // clock and logic reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // control pins
    input  wire logic              conversion_start_n,
    input  wire logic              resetIn,
    input  wire logic              power_down_in,
    input  wire logic              chipSelN,
    input  wire logic              readN,
    // configuration pins
    input  wire logic              range_scale_select,
    input  wire logic              bipolarSelect,
    input  wire logic              output_coding_select,
    input  wire logic              serial_parallel_select,
    input  wire logic              clock_source_select,
    input  wire logic              read_during_convert,
    input  wire logic              swConfigN,
    // serial configuration write
    input  wire logic              cfgWrite,
    input  wire logic [3:0]        cfgData,
    // slave serial clock and converter result
    input  wire logic              extSerialClk,
    input  wire logic [DATA_W-1:0] convResult,
    // status and output bus
    output logic                   busy,
    output logic                   holdSample,
    output logic [1:0]             inputRange,
    output logic                   outputEnable,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   serialClkGated
);
    acc_pin_if pins();

    acc_pin_sync u_sync (
        .mclk               (mclk),
        .rst                (rst),
        .conversion_start_n (conversion_start_n),
        .resetIn            (resetIn),
        .power_down_in      (power_down_in),
        .chipSelN           (chipSelN),
        .readN              (readN),
        .extSerialClk       (extSerialClk),
        .pins               (pins)
    );

    typedef struct packed {
        acc_state_t        state;
        logic [CNT_W-1:0]  count;
        logic              startPrev;
        logic              resetPrev;
        logic [DATA_W-1:0] data;
        logic [3:0]        cfg;
        logic [6:0]        strapS1;
        logic [6:0]        strapS2;
    } acc_ctrl_t;

    acc_ctrl_t ctrlReg;
    acc_ctrl_t ctrlNext;

    logic       swMode;
    logic       masterRac;
    logic       pdEff;
    logic       startFall;
    logic       scaleSel;
    logic       bipolarSel;
    logic       codingSel;
    logic       serialSel;
    logic       clkSrcSel;
    logic       rdcSel;
    logic       swCfgN;
    logic [CNT_W-1:0] convLen;

    function automatic logic [1:0] range_decode(input logic scale,
                                                input logic bipolar);
        range_decode = {bipolar, scale};
    endfunction

    // strap pins are asynchronous: read only after two flops
    assign {scaleSel, bipolarSel, codingSel, serialSel, clkSrcSel, rdcSel,
            swCfgN} = ctrlReg.strapS2;
    assign swMode    = serialSel & ~swCfgN;
    assign masterRac = serialSel & ~clkSrcSel & ~rdcSel;
    assign pdEff     = swMode ? ctrlReg.cfg[CFG_PD_BIT]
                              : pins.powerDown;
    assign startFall = ctrlReg.startPrev & ~pins.startN;
    assign convLen   = masterRac ?
        CNT_W'(CONV_CYCLES + CONV_EXTRA_CYCLES) :
        CNT_W'(CONV_CYCLES);

    always_comb begin
        ctrlNext           = ctrlReg;
        ctrlNext.startPrev = pins.startN;
        ctrlNext.resetPrev = pins.resetPin;
        ctrlNext.strapS1   = {range_scale_select, bipolarSelect,
                              output_coding_select, serial_parallel_select,
                              clock_source_select, read_during_convert,
                              swConfigN};
        ctrlNext.strapS2   = ctrlReg.strapS1;
        if (swMode && cfgWrite) begin
            ctrlNext.cfg = cfgData;
        end
        case (ctrlReg.state)
            ST_IDLE: begin
                if (startFall && !pdEff) begin
                    ctrlNext.state = ST_CONV;
                    ctrlNext.count = convLen;
                end
            end
            ST_CONV: begin
                if (ctrlReg.count <= CNT_W'(1)) begin
                    ctrlNext.data  = convResult;
                    ctrlNext.state = ST_DONE;
                end else begin
                    ctrlNext.count = ctrlReg.count - CNT_W'(1);
                end
            end
            ST_DONE: ctrlNext.state = ST_IDLE;
            default: ctrlNext.state = ST_IDLE;
        endcase
        if (pins.resetPin) begin
            ctrlNext.state = ST_IDLE;
            ctrlNext.count = '0;
            // an aborted conversion leaves the old result in place
            ctrlNext.data  = ctrlReg.data;
        end
        if (ctrlReg.resetPrev && !pins.resetPin) begin
            ctrlNext.cfg = CFG_RESET;
            if (codingSel) begin
                ctrlNext.data = DATA_RESET;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrlReg <= '{state: ST_IDLE, count: '0, startPrev: 1'b1,
                         resetPrev: 1'b0, data: DATA_RESET,
                         cfg: CFG_RESET, strapS1: STRAP_RESET,
                         strapS2: STRAP_RESET};
        end else begin
            ctrlReg <= ctrlNext;
        end
    end

    assign busy         = (ctrlReg.state == ST_CONV);
    assign holdSample   = busy;
    assign inputRange   = swMode ?
        range_decode(ctrlReg.cfg[CFG_SCALE_BIT],
                     ctrlReg.cfg[CFG_BIPOLAR_BIT]) :
        range_decode(scaleSel, bipolarSel);
    assign outputEnable = ~pins.csN & ~pins.rdN;
    assign dataOut      = ctrlReg.data;
    assign serialClkGated = serialSel & clkSrcSel
                            & ~pins.csN & pins.serialClk;

    property p_busy_rise;
        @(posedge mclk) disable iff (rst)
        (ctrlReg.state == ST_IDLE && startFall && !pdEff
         && !pins.resetPin) |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy did not rise on start");

    sequence s_conv_start;
        !busy ##1 busy;
    endsequence
    property p_busy_len;
        @(posedge mclk) disable iff (rst || pins.resetPin)
        s_conv_start |-> busy [*2];
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy too short");

    property p_latch;
        @(posedge mclk) disable iff (rst)
        (busy && !pins.resetPin && ctrlReg.count == CNT_W'(1))
        |=> (!busy && dataOut == $past(convResult));
    endproperty
    a_latch: assert property (p_latch)
        else $error("result not latched at busy fall");

    property p_rac_len;
        @(posedge mclk) disable iff (rst)
        (ctrlReg.state == ST_IDLE && startFall && !pdEff
         && masterRac && !pins.resetPin)
        |=> ctrlReg.count == CNT_W'(CONV_CYCLES + CONV_EXTRA_CYCLES);
    endproperty
    a_rac_len: assert property (p_rac_len)
        else $error("read-after-convert busy not lengthened");

    property p_range;
        @(posedge mclk) disable iff (rst)
        !swMode |-> inputRange == {$past(bipolarSelect, 2),
                                   $past(range_scale_select, 2)};
    endproperty
    a_range: assert property (p_range)
        else $error("range decode wrong");

    property p_oe;
        @(posedge mclk) disable iff (rst)
        outputEnable == (!$past(chipSelN, 2) && !$past(readN, 2));
    endproperty
    a_oe: assert property (p_oe)
        else $error("output enable without cs and rd");

    property p_abort;
        @(posedge mclk) disable iff (rst)
        pins.resetPin |=> !busy;
    endproperty
    a_abort: assert property (p_abort)
        else $error("conversion not aborted by reset");

    property p_reset_fall;
        @(posedge mclk) disable iff (rst)
        (ctrlReg.resetPrev && !pins.resetPin && codingSel)
        |=> (dataOut == DATA_RESET && ctrlReg.cfg == CFG_RESET);
    endproperty
    a_reset_fall: assert property (p_reset_fall)
        else $error("reset fall did not clear outputs");

    property p_pd_block;
        @(posedge mclk) disable iff (rst)
        (!busy && pdEff) |=> !busy;
    endproperty
    a_pd_block: assert property (p_pd_block)
        else $error("conversion started in power-down");

    property p_pd_finish;
        @(posedge mclk) disable iff (rst || pins.resetPin)
        (busy && ctrlReg.count > CNT_W'(1)) |=> busy;
    endproperty
    a_pd_finish: assert property (p_pd_finish)
        else $error("conversion cut short");
endmodule

// >>> rtl/acc_pin_if.sv
// Purpose: synchronised pin levels passed from the sampler to the core
// Assumes: one clock domain
// Notes:   all signals already pass two flip-flops
interface acc_pin_if;
    logic startN;
    logic resetPin;
    logic powerDown;
    logic csN;
    logic rdN;
    logic serialClk;
    modport src (output startN, resetPin, powerDown, csN, rdN, serialClk);
    modport dst (input  startN, resetPin, powerDown, csN, rdN, serialClk);
endinterface

// >>> rtl/acc_pin_sync.sv
// Purpose: two-flop synchronisers for the asynchronous control pins
// Assumes: pins idle high except reset, power-down and serial clock
// Notes:   first stage feeds only the second stage
module acc_pin_sync
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic    mclk,
    input  wire logic    rst,
    // raw pins
    input  wire logic    conversion_start_n,
    input  wire logic    resetIn,
    input  wire logic    power_down_in,
    input  wire logic    chipSelN,
    input  wire logic    readN,
    input  wire logic    extSerialClk,
    // synchronised levels
    acc_pin_if.src       pins
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
    } acc_sync_t;

    acc_sync_t syncReg;
    acc_sync_t syncNext;

    always_comb begin
        syncNext    = syncReg;
        syncNext.s1 = {conversion_start_n, resetIn, power_down_in,
                       chipSelN, readN, extSerialClk};
        syncNext.s2 = syncReg.s1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            syncReg <= '{s1: SYNC_RESET, s2: SYNC_RESET};
        end else begin
            syncReg <= syncNext;
        end
    end

    assign pins.startN    = syncReg.s2[5];
    assign pins.resetPin  = syncReg.s2[4];
    assign pins.powerDown = syncReg.s2[3];
    assign pins.csN       = syncReg.s2[2];
    assign pins.rdN       = syncReg.s2[1];
    assign pins.serialClk = syncReg.s2[0];
endmodule

// >>> rtl/acc_pkg.sv
// Purpose: constants and types for the conversion control pins
// Assumes: 125 MHz mclk
// Notes:   conversion time is modelled by cycle counts
package acc_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned CONV_TIME_NS    = 1000;
    localparam int unsigned CONV_EXTRA_NS   = 480;
    localparam int unsigned CONV_CYCLES     =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_EXTRA_CYCLES =
        (CONV_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 8;
    localparam int unsigned DATA_W          = 16;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [3:0]  CFG_RESET       = 4'h0;
    // synchroniser reset levels match the idle level of each pin
    localparam logic [5:0]  SYNC_RESET      = 6'h26;
    localparam logic [6:0]  STRAP_RESET     = 7'h01;
    // configuration register fields
    localparam int unsigned CFG_SCALE_BIT   = 0;
    localparam int unsigned CFG_BIPOLAR_BIT = 1;
    localparam int unsigned CFG_PD_BIT      = 2;

    typedef enum logic [1:0] {
        RANGE_0_5   = 2'b00,
        RANGE_0_10  = 2'b01,
        RANGE_PM5   = 2'b10,
        RANGE_PM10  = 2'b11
    } acc_range_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b10
    } acc_state_t;
endpackage
